// ### ast_consts.svh
// Register offsets, bit positions, reset values and timing counts
`ifndef AST_CONSTS_SVH
`define AST_CONSTS_SVH
`define AST_ADDR_W           8
`define AST_OFF_INTCTL       8'h0B
`define AST_OFF_PFLAGS       8'h0C
`define AST_OFF_RXCTL        8'h18
`define AST_OFF_TXBUF        8'h19
`define AST_OFF_RXFIFO       8'h1A
`define AST_OFF_PMASK        8'h8C
`define AST_OFF_TXCTL        8'h98
`define AST_OFF_BAUD         8'h99
`define AST_OFF_CTRL         8'hA0
`define AST_TX_CLOCK_SOURCE_SELECT          7
`define AST_TX_NINE          6
`define AST_TX_EN            5
`define AST_TX_SYNC          4
`define AST_TX_BAUD_HIGH_SPEED          2
`define AST_TX_SHIFT_OUT_EMPTY_STATUS          1
`define AST_TX_NINED         0
`define AST_RX_SERIAL_PORT_ENABLE          7
`define AST_RX_NINE          6
`define AST_RX_SINGLE_RECEIVE_ENABLE          5
`define AST_RX_CONTINUOUS_RECEIVE_ENABLE          4
`define AST_RX_FRAMING_ERROR_FLAG          2
`define AST_RX_OVERRUN_FLAG          1
`define AST_RX_NINED         0
`define AST_PF_RXIF          5
`define AST_PF_TX_BUFFER_EMPTY_FLAG          4
`define AST_TXCTL_RST        8'h02
`define AST_ZERO8            8'h00
`define AST_OVS_LO           7'h0F
`define AST_OVS_HI           7'h3F
`define AST_TCY_CLKS         4
`define AST_FIFO_DEPTH       2
`endif

// ### ast_peer.sv
// Remote serial peer: sends frames and catches the device's frames
`timescale 1ns/10ps
module ast_peer (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_line
);
  int         t_bit = 32;
  int         rx_bits = 8;
  logic [8:0] rx_q[$];
  logic [8:0] sh;

  initial o_line = 1'b1;

  // ----------------------------------------
  // Frame sender, stop level chosen by caller
  // ----------------------------------------
  task automatic send(input logic [8:0] v, input int nb, input logic stop_bit);
    o_line <= 1'b0;
    repeat (t_bit) @(posedge i_clk);
    for (int i = 0; i < nb; i++) begin
      o_line <= v[i];
      repeat (t_bit) @(posedge i_clk);
    end
    o_line <= stop_bit;
    repeat (t_bit) @(posedge i_clk);
    o_line <= 1'b1;
    @(posedge i_clk); // One idle clock so back-to-back frames never reassign the line
  endtask

  // ----------------------------------------
  // Frame catcher, samples each bit mid-cell
  // ----------------------------------------
  always begin
    @(negedge i_line);
    repeat (t_bit / 2) @(posedge i_clk);
    if (i_line == 1'b0) begin
      sh = 9'h000;
      for (int i = 0; i < rx_bits; i++) begin
        repeat (t_bit) @(posedge i_clk);
        sh[i] = i_line;
      end
      repeat (t_bit) @(posedge i_clk);
      rx_q.push_back(sh);
    end
  end
endmodule // ast_peer

// ### ast_pkg.sv
// Types shared by the serial transceiver
package ast_pkg;
  typedef enum logic [1:0] {
    AST_IDLE  = 2'b00,
    AST_START = 2'b01,
    AST_DATA  = 2'b10,
    AST_STOP  = 2'b11
  } ast_state_t;
  typedef struct packed {
    logic       framing_error_flag;
    logic       nine;
    logic [7:0] data;
  } ast_rxword_t;
endpackage

// ### ast_uart.sv
// Asynchronous serial transmitter and receiver with register port
`timescale 1ns/10ps
`include "ast_consts.svh"
module ast_uart
  import ast_pkg::*;
#(
  parameter int TCY = `AST_TCY_CLKS
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_ce,
  input  wire logic       i_sleep,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_serial_in_pin,
  output logic            o_serial_out_pin,
  output logic            o_serial_out_pin_oe,
  output logic            o_tx_irq,
  output logic            o_rx_irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] txctl_q, rxctl_q, baud_q, pmask_q, intctl_q, txbuf_q;
  logic       txbuf_full_q, tx_buffer_empty_flag_q, shift_out_empty_status_q, overrun_flag_q;
  logic       go, tx_en, rx_en, brg_run, tick;
  logic       wr_txbuf, rd_fifo, load_tsr, tsr_busy;
  logic [1:0] cnt_q;
  ast_rxword_t fifo_q [`AST_FIFO_DEPTH];
  ast_rxword_t head;
  logic       rx_done;
  ast_rxword_t rx_word;

  assign go       = i_ce && !i_sleep;
  assign tx_en    = txctl_q[`AST_TX_EN] && !txctl_q[`AST_TX_SYNC]
                    && rxctl_q[`AST_RX_SERIAL_PORT_ENABLE];
  assign rx_en    = rxctl_q[`AST_RX_CONTINUOUS_RECEIVE_ENABLE] && !txctl_q[`AST_TX_SYNC]
                    && rxctl_q[`AST_RX_SERIAL_PORT_ENABLE];
  assign brg_run  = txctl_q[`AST_TX_EN] || rxctl_q[`AST_RX_CONTINUOUS_RECEIVE_ENABLE]
                    || rxctl_q[`AST_RX_SINGLE_RECEIVE_ENABLE];
  assign wr_txbuf = i_wr && (i_addr == `AST_OFF_TXBUF);
  assign rd_fifo  = i_rd && (i_addr == `AST_OFF_RXFIFO) && (cnt_q != 2'd0);
  assign head     = fifo_q[0];

  // Control register writes
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      txctl_q  <= `AST_TXCTL_RST;
      rxctl_q  <= `AST_ZERO8;
      baud_q   <= `AST_ZERO8;
      pmask_q  <= `AST_ZERO8;
      intctl_q <= `AST_ZERO8;
    end else if (i_ce && i_wr) begin
      case (i_addr)
        `AST_OFF_TXCTL:  txctl_q  <= {i_wdata[7:2], 1'b0, i_wdata[0]};
        `AST_OFF_RXCTL:  rxctl_q  <= {i_wdata[7:4], 4'h0};
        `AST_OFF_BAUD:   baud_q   <= i_wdata;
        `AST_OFF_PMASK:  pmask_q  <= i_wdata;
        `AST_OFF_INTCTL: intctl_q <= i_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  logic [7:0] brg_q;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      brg_q <= `AST_ZERO8;
    end else if (i_ce) begin
      if (!brg_run) brg_q <= baud_q;
      else if (go) brg_q <= (brg_q == 8'h00) ? baud_q : brg_q - 8'h01;
    end
  end
  assign tick = go && brg_run && (brg_q == 8'h00);

  // Tick prescaler for the bit clock, x16 or x64
  logic [6:0] ovs_lim;
  logic [6:0] txdiv_q;
  logic       bit_tick;
  assign ovs_lim  = txctl_q[`AST_TX_BAUD_HIGH_SPEED] ? `AST_OVS_LO : `AST_OVS_HI;
  // At-or-above limit so a switch from x64 to x16 mid-count cannot wrap
  assign bit_tick = tick && (txdiv_q >= ovs_lim);
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) txdiv_q <= 7'h00;
    else if (i_ce && tick) txdiv_q <= (txdiv_q >= ovs_lim) ? 7'h00 : txdiv_q + 7'h01;
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  ast_state_t tx_st_q;
  logic [8:0] tsr_q;
  logic [3:0] tbit_q;
  logic       txout_q, txoe_q;
  assign tsr_busy = (tx_st_q != AST_IDLE);
  assign load_tsr = go && tx_en && !tsr_busy && txbuf_full_q;

  // Transmit buffer and its full marker
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      txbuf_q      <= `AST_ZERO8;
      txbuf_full_q <= 1'b0;
    end else if (i_ce) begin
      if (wr_txbuf) begin
        txbuf_q      <= i_wdata;
        txbuf_full_q <= 1'b1;
      end else if (load_tsr || !txctl_q[`AST_TX_EN]) begin
        txbuf_full_q <= txctl_q[`AST_TX_EN] ? 1'b0 : txbuf_full_q;
      end
    end
  end

  // Flag timing in instruction cycles
  logic [3:0] tcy_q;
  logic       tx_buffer_empty_flag_pend_q;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tcy_q       <= 4'h0;
      tx_buffer_empty_flag_pend_q <= 1'b0;
      tx_buffer_empty_flag_q      <= 1'b0;
      shift_out_empty_status_q      <= 1'b1;
    end else if (i_ce) begin
      tcy_q <= (tcy_q == 4'(TCY - 1)) ? 4'h0 : tcy_q + 4'h1;
      if (load_tsr) tx_buffer_empty_flag_pend_q <= 1'b1;
      else if (tcy_q == 4'(TCY - 1)) tx_buffer_empty_flag_pend_q <= 1'b0;
      if (tcy_q == 4'(TCY - 1)) shift_out_empty_status_q <= !tsr_busy;
      if ((tcy_q == 4'(TCY - 1) && tx_buffer_empty_flag_pend_q)
          || (i_wr && i_addr == `AST_OFF_TXCTL && i_wdata[`AST_TX_EN]
              && !txctl_q[`AST_TX_EN]))
        tx_buffer_empty_flag_q <= 1'b1;
      else if (wr_txbuf) tx_buffer_empty_flag_q <= 1'b0;
    end
  end

  // Frame shifter: start, data, optional ninth, stop
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_st_q <= AST_IDLE;
      tsr_q   <= 9'h000;
      tbit_q  <= 4'h0;
      txout_q <= 1'b1;
      txoe_q  <= 1'b0;
    end else if (i_ce) begin
      txoe_q <= tx_en;
      if (!tx_en) begin
        tx_st_q <= AST_IDLE;
        txout_q <= 1'b1;
      end else if (load_tsr) begin
        // Always from the buffer: a colliding write stays queued, not doubled
        tsr_q   <= {txctl_q[`AST_TX_NINED], txbuf_q};
        tx_st_q <= AST_START;
      end else if (go && bit_tick) begin
        case (tx_st_q)
          AST_START: begin
            txout_q <= 1'b0;
            tbit_q  <= txctl_q[`AST_TX_NINE] ? 4'd9 : 4'd8;
            tx_st_q <= AST_DATA;
          end
          AST_DATA: begin
            txout_q <= tsr_q[0];
            tsr_q   <= {1'b0, tsr_q[8:1]};
            tbit_q  <= tbit_q - 4'h1;
            if (tbit_q == 4'h1) tx_st_q <= AST_STOP;
          end
          AST_STOP: begin
            txout_q <= 1'b1;
            tx_st_q <= AST_IDLE;
          end
          default: tx_st_q <= AST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  ast_state_t rx_st_q;
  logic [3:0] rph_q;
  logic [3:0] rbit_q;
  logic [8:0] rsr_q;
  logic       rxd_q, rxprev_q, rx_tick;
  logic [1:0] rdiv_q;
  // x64 mode thins ticks by four so recovery always runs at x16
  assign rx_tick = tick && (txctl_q[`AST_TX_BAUD_HIGH_SPEED] || rdiv_q == 2'd3);
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) rdiv_q <= 2'd0;
    else if (i_ce && tick) rdiv_q <= rdiv_q + 2'd1;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_st_q  <= AST_IDLE;
      rph_q    <= 4'h0;
      rbit_q   <= 4'h0;
      rsr_q    <= 9'h000;
      rxd_q    <= 1'b1;
      rxprev_q <= 1'b1;
      rx_done  <= 1'b0;
      rx_word  <= '0;
    end else if (i_ce) begin
      rx_done <= 1'b0;
      if (!rx_en) begin
        rx_st_q <= AST_IDLE;
      end else if (rx_tick) begin
        rxd_q    <= i_serial_in_pin;
        rxprev_q <= rxd_q;
        rph_q    <= rph_q + 4'h1;
        case (rx_st_q)
          AST_IDLE: if (rxprev_q && !rxd_q) begin
            rx_st_q <= AST_START;
            rph_q   <= 4'h1;
          end
          AST_START: if (rph_q == 4'h7) begin
            rx_st_q <= rxd_q ? AST_IDLE : AST_DATA;
            rph_q   <= 4'h0;
            rbit_q  <= rxctl_q[`AST_RX_NINE] ? 4'd9 : 4'd8;
          end
          AST_DATA: if (rph_q == 4'hF) begin
            rsr_q  <= rxctl_q[`AST_RX_NINE] ? {rxd_q, rsr_q[8:1]}
                                             : {1'b0, rxd_q, rsr_q[7:1]};
            rbit_q <= rbit_q - 4'h1;
            if (rbit_q == 4'h1) rx_st_q <= AST_STOP;
          end
          AST_STOP: if (rph_q == 4'hF) begin
            rx_st_q <= AST_IDLE;
            rx_done <= 1'b1;
            rx_word <= '{framing_error_flag: !rxd_q, nine: rsr_q[8], data: rsr_q[7:0]};
          end
          default: rx_st_q <= AST_IDLE;
        endcase
      end
    end
  end

  // Two-word receive FIFO with overrun
  logic push;
  assign push = rx_done && !overrun_flag_q && (cnt_q != 2'd2 || rd_fifo);
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q  <= 2'd0;
      overrun_flag_q <= 1'b0;
      for (int k = 0; k < `AST_FIFO_DEPTH; k++) fifo_q[k] <= '0;
    end else if (i_ce) begin
      if (rx_done && !overrun_flag_q && cnt_q == 2'd2 && !rd_fifo) overrun_flag_q <= 1'b1;
      else if (!rxctl_q[`AST_RX_CONTINUOUS_RECEIVE_ENABLE]) overrun_flag_q <= 1'b0;
      if (rd_fifo) fifo_q[0] <= fifo_q[1];
      if (push) fifo_q[(rd_fifo ? cnt_q - 2'd1 : cnt_q) == 2'd0 ? 0 : 1] <= rx_word;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, rd_fifo};
    end
  end

  // ----------------------------------------------------------------
  // Read port and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= `AST_ZERO8;
    end else if (i_ce) begin
      o_rdata <= `AST_ZERO8;
      if (i_rd) begin
        case (i_addr)
          `AST_OFF_TXCTL:  o_rdata <= {txctl_q[7:2], shift_out_empty_status_q, txctl_q[0]};
          `AST_OFF_RXCTL:  o_rdata <= {rxctl_q[7:4], 1'b0, head.framing_error_flag, overrun_flag_q, head.nine};
          `AST_OFF_PFLAGS: o_rdata <= {2'b00, cnt_q != 2'd0, tx_buffer_empty_flag_q, 4'h0};
          `AST_OFF_RXFIFO: o_rdata <= head.data;
          `AST_OFF_TXBUF:  o_rdata <= txbuf_q;
          `AST_OFF_BAUD:   o_rdata <= baud_q;
          `AST_OFF_PMASK:  o_rdata <= pmask_q;
          `AST_OFF_INTCTL: o_rdata <= intctl_q;
          default:         o_rdata <= `AST_ZERO8;
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_serial_out_pin    <= 1'b1;
      o_serial_out_pin_oe <= 1'b0;
      o_tx_irq            <= 1'b0;
      o_rx_irq            <= 1'b0;
    end else if (i_ce) begin
      o_serial_out_pin    <= txout_q;
      o_serial_out_pin_oe <= txoe_q;
      o_tx_irq            <= tx_buffer_empty_flag_q && pmask_q[`AST_PF_TX_BUFFER_EMPTY_FLAG];
      o_rx_irq            <= (cnt_q != 2'd0) && pmask_q[`AST_PF_RXIF];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  brg_hold_a: assert property (!brg_run && i_ce |=> brg_q == $past(baud_q))
    else $error("baud divider not held");
  tx_buffer_empty_flag_clear_a: assert property (i_ce && wr_txbuf && !tx_buffer_empty_flag_pend_q |=> !tx_buffer_empty_flag_q)
    else $error("buffer-empty flag not cleared by write");
  abort_a: assert property (i_ce && !tx_en |=> tx_st_q == AST_IDLE)
    else $error("transmit not aborted");
  load_a: assert property (load_tsr |=> tx_st_q == AST_START)
    else $error("shifter not loaded");
  ovf_a: assert property (i_ce && rx_done && !overrun_flag_q && cnt_q == 2'd2 && !rd_fifo
                          |=> overrun_flag_q && cnt_q == 2'd2)
    else $error("overrun not flagged");
  ovr_hold_a: assert property (overrun_flag_q && i_ce && !rd_fifo |=> cnt_q == $past(cnt_q))
    else $error("word entered during overrun");
  fifo_max_a: assert property (cnt_q <= 2'd2)
    else $error("fifo count too large");
  rd_data_a: assert property (i_ce && i_rd && i_addr == `AST_OFF_RXFIFO
                              |=> o_rdata == $past(head.data))
    else $error("fifo read data wrong");
  tx_cv: cover property (tx_st_q == AST_STOP ##1 tx_st_q == AST_IDLE);
  rx_cv: cover property (rx_done);
  ovr_cv: cover property ($rose(overrun_flag_q));
endmodule // ast_uart

// ### tb.sv
// Self-checking bench for the serial transceiver
`timescale 1ns/10ps
`include "ast_consts.svh"
module tb;
  logic       sys_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       sleep = 1'b0;
  logic       ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       rx_line;
  logic       tx_pin;
  logic       tx_oe;
  logic       tx_irq;
  logic       rx_irq;
  wire        tx_line = tx_oe ? tx_pin : 1'b1;
  int         failures = 0;
  int         n_compared = 0;
  int         cyc = 0;

  ast_uart #(.TCY(4)) u_ast_uart (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_ce(ce),
    .i_sleep(sleep), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_serial_in_pin(rx_line), .o_serial_out_pin(tx_pin), .o_serial_out_pin_oe(tx_oe),
    .o_tx_irq(tx_irq), .o_rx_irq(rx_irq));
  ast_peer u_ast_peer (.i_clk(sys_clk), .i_line(tx_line), .o_line(rx_line));

  // Clock and hang guard
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Bus, compare and wait helpers
  // ----------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic chk_rd(input string n, input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk(n, {1'b0, rdata}, {1'b0, exp});
  endtask
  task automatic pop(input string n, input logic [8:0] exp);
    int k;
    k = 0;
    while (u_ast_peer.rx_q.size() == 0 && k < 3000) begin
      @(posedge sys_clk);
      k++;
    end
    chk(n, (u_ast_peer.rx_q.size() != 0) ? u_ast_peer.rx_q.pop_front() : 9'hxxx, exp);
  endtask
  task automatic bits(input int n);
    repeat (n * u_ast_peer.t_bit) @(posedge sys_clk);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    chk_rd("txctl", `AST_OFF_TXCTL, 8'h02);
    chk_rd("pflags", `AST_OFF_PFLAGS, 8'h00);
    chk_rd("baud", `AST_OFF_BAUD, 8'h00);
    chk_rd("pmask", `AST_OFF_PMASK, 8'h00);
    wr_reg(8'h50, 8'hFF);
    chk_rd("unmapped", 8'h50, 8'h00);
    ce <= 1'b0;
    wr_reg(`AST_OFF_BAUD, 8'h55);
    ce <= 1'b1;
    chk_rd("frozen", `AST_OFF_BAUD, 8'h00);
    $display("test reset done");
    // Transmit: enable, flags, back-to-back bytes
    wr_reg(`AST_OFF_BAUD, 8'h01);
    wr_reg(`AST_OFF_RXCTL, 8'h90);
    wr_reg(`AST_OFF_TXCTL, 8'h24);
    repeat (8) @(posedge sys_clk);
    chk_rd("tx_buffer_empty_flag on enable", `AST_OFF_PFLAGS, 8'h10);
    chk_rd("shift_out_empty_status idle", `AST_OFF_TXCTL, 8'h26);
    wr_reg(`AST_OFF_PMASK, 8'h10);
    repeat (2) @(posedge sys_clk);
    chk("tx irq on", {8'h00, tx_irq}, 9'h001);
    wr_reg(`AST_OFF_PMASK, 8'h20);
    repeat (2) @(posedge sys_clk);
    chk("tx irq masked", {8'h00, tx_irq}, 9'h000);
    wr_reg(`AST_OFF_TXBUF, 8'hA5);
    repeat (8) @(posedge sys_clk);
    chk_rd("tx_buffer_empty_flag after move", `AST_OFF_PFLAGS, 8'h10);
    chk_rd("shift_out_empty_status loaded", `AST_OFF_TXCTL, 8'h24);
    wr_reg(`AST_OFF_TXBUF, 8'h3C);
    chk_rd("tx_buffer_empty_flag full", `AST_OFF_PFLAGS, 8'h00);
    pop("byte a", 9'h0A5);
    pop("byte b", 9'h03C);
    bits(2);
    chk_rd("tx_buffer_empty_flag end", `AST_OFF_PFLAGS, 8'h10);
    chk_rd("shift_out_empty_status end", `AST_OFF_TXCTL, 8'h26);
    $display("test transmit done");
    // Nine-bit send, then x64 rate
    wr_reg(`AST_OFF_TXCTL, 8'h65);
    u_ast_peer.rx_bits = 9;
    wr_reg(`AST_OFF_TXBUF, 8'h81);
    pop("nine bit send", 9'h181);
    u_ast_peer.rx_bits = 8;
    wr_reg(`AST_OFF_TXCTL, 8'h20);
    u_ast_peer.t_bit = 128;
    wr_reg(`AST_OFF_TXBUF, 8'h96);
    pop("x64 byte", 9'h096);
    u_ast_peer.send(9'h0C9, 8, 1'b1);
    repeat (4) @(posedge sys_clk);
    chk_rd("x64 rx", `AST_OFF_RXFIFO, 8'hC9);
    u_ast_peer.t_bit = 32;
    wr_reg(`AST_OFF_TXCTL, 8'h24);
    // Sleep halts the transmitter
    sleep <= 1'b1;
    wr_reg(`AST_OFF_TXBUF, 8'h11);
    bits(12);
    chk("sleep quiet", 9'(u_ast_peer.rx_q.size()), 9'h000);
    sleep <= 1'b0;
    pop("after sleep", 9'h011);
    $display("test transmit modes done");
    // Receive beside a transmit
    fork
      u_ast_peer.send(9'h05A, 8, 1'b1);
      wr_reg(`AST_OFF_TXBUF, 8'hC4);
    join
    repeat (4) @(posedge sys_clk);
    chk_rd("rxif set", `AST_OFF_PFLAGS, 8'h30);
    chk("rx irq", {8'h00, rx_irq}, 9'h001);
    chk_rd("rx status", `AST_OFF_RXCTL, 8'h90);
    chk_rd("rx byte", `AST_OFF_RXFIFO, 8'h5A);
    chk_rd("rxif clear", `AST_OFF_PFLAGS, 8'h10);
    pop("tx beside rx", 9'h0C4);
    // Overrun: third word lost, blocked until enable toggles
    u_ast_peer.send(9'h001, 8, 1'b1);
    u_ast_peer.send(9'h002, 8, 1'b1);
    u_ast_peer.send(9'h003, 8, 1'b1);
    repeat (4) @(posedge sys_clk);
    chk_rd("overrun", `AST_OFF_RXCTL, 8'h92);
    chk_rd("fifo one", `AST_OFF_RXFIFO, 8'h01);
    chk_rd("fifo two", `AST_OFF_RXFIFO, 8'h02);
    u_ast_peer.send(9'h004, 8, 1'b1);
    repeat (4) @(posedge sys_clk);
    chk_rd("blocked", `AST_OFF_PFLAGS, 8'h10);
    wr_reg(`AST_OFF_RXCTL, 8'h80);
    wr_reg(`AST_OFF_RXCTL, 8'h90);
    chk_rd("overrun clear", `AST_OFF_RXCTL, 8'h90);
    $display("test overrun done");
    // Framing error and ninth bit travel with each word
    u_ast_peer.send(9'h077, 8, 1'b0);
    bits(1);
    u_ast_peer.send(9'h078, 8, 1'b1);
    repeat (4) @(posedge sys_clk);
    chk_rd("framing_error_flag head", `AST_OFF_RXCTL, 8'h94);
    chk_rd("framing_error_flag byte", `AST_OFF_RXFIFO, 8'h77);
    chk_rd("framing_error_flag next", `AST_OFF_RXCTL, 8'h90);
    chk_rd("good byte", `AST_OFF_RXFIFO, 8'h78);
    wr_reg(`AST_OFF_RXCTL, 8'hD0);
    u_ast_peer.send(9'h1C3, 9, 1'b1);
    repeat (4) @(posedge sys_clk);
    chk_rd("ninth rx", `AST_OFF_RXCTL, 8'hD1);
    chk_rd("ninth byte", `AST_OFF_RXFIFO, 8'hC3);
    $display("test receive errors done");
    // Abort a frame by clearing transmit enable
    wr_reg(`AST_OFF_TXBUF, 8'hFF);
    bits(3);
    wr_reg(`AST_OFF_TXCTL, 8'h04);
    repeat (8) @(posedge sys_clk);
    chk("pin released", {8'h00, tx_oe}, 9'h000);
    chk_rd("shift_out_empty_status abort", `AST_OFF_TXCTL, 8'h06);
    bits(10);
    u_ast_peer.rx_q.delete();
    wr_reg(`AST_OFF_TXBUF, 8'h5B);
    wr_reg(`AST_OFF_TXCTL, 8'h24);
    pop("preload start", 9'h05B);
    $display("test abort done");
    tally_and_finish();
  end
endmodule // tb
